// *** hw/lfp_consts.svh ***
`ifndef LFP_CONSTS_SVH
`define LFP_CONSTS_SVH

// Flash word address width
`define LFP_ADDR_W 14
// Register byte offsets
`define LFP_OFF_LOCK 8'h00
`define LFP_OFF_FUSE 8'h04
`define LFP_OFF_NV 8'h08
`define LFP_OFF_CMD 8'h0c
`define LFP_OFF_STAT 8'h10
// Reset images: all locks erased, fuse factory image
`define LFP_LOCK_RST 6'h3f
`define LFP_FUSE_RST 13'h13f2
// Command word fields
`define LFP_CMD_OP_MSB 2
`define LFP_CMD_IF_LSB 4
`define LFP_CMD_IF_MSB 5
`define LFP_CMD_DAT_LSB 16
`define LFP_CMD_DAT_MSB 28
// Field position of the fuse image in the nonvolatile readback word
`define LFP_NV_FUSE_LSB 16
// Chip erase length in clock cycles
`define LFP_ERASE_CYCLES 16

`endif

// *** hw/lfp_pkg.sv ***
`include "lfp_consts.svh"

package lfp_pkg;
  // Lock bits, 1 = unprogrammed
  typedef struct packed {
    logic bootGuardHigh;
    logic bootGuardLow;
    logic appGuardHigh;
    logic appGuardLow;
    logic basicLockHigh;
    logic basicLockLow;
  } lfp_lock_type;

  // Fuse bits, 1 = unprogrammed
  typedef struct packed {
    logic debugEnableFuse;
    logic scanPortEnableFuse;
    logic serialDownloadEnableFuse;
    logic eepromRetainFuse;
    logic [1:0] bootSizeSelect;
    logic bootResetSelect;
    logic brownoutLevelFuse;
    logic brownoutEnableFuse;
    logic [3:0] clockSourceSelect;
  } lfp_fuse_type;

  // CPU program memory access
  typedef struct packed {
    logic inBoot;
    logic store;
    logic read;
    logic [`LFP_ADDR_W-1:0] addr;
  } lfp_cpu_req_type;

  // Decoded static configuration
  typedef struct packed {
    logic debugOn;
    logic scanPortOn;
    logic serialDownloadOn;
    logic brownoutOn;
    logic brownoutLevel;
    logic [3:0] clockSource;
    logic [`LFP_ADDR_W-1:0] resetVector;
  } lfp_cfg_type;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_LOCK = 3'b001,
    OP_FUSE_HIGH = 3'b010,
    OP_FUSE_LOW = 3'b011,
    OP_ERASE = 3'b100
  } lfp_op_type;

  typedef enum logic [1:0] {
    IF_PARALLEL = 2'b00,
    IF_SERIAL = 2'b01,
    IF_SCAN = 2'b10
  } lfp_iface_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE_MEM = 2'b01,
    ST_ERASE_LOCK = 2'b10
  } lfp_state_type;
endpackage : lfp_pkg

// *** hw/lfp_decode.sv ***
// Contract
// - Six lock bits, 1 unprogrammed, 0 programmed
// - Only chip erase returns locks to 1
// - Mode 1: no programming restrictions
// - Mode 2: no memory writes, fuses locked; scan interface can still write fuses here
// - Mode 3: no writes or verify reads
// - App guard low blocks stores to application
// - App guard high blocks boot reads of application
// - App guard high, boot vectors: mask application interrupts
// - Boot guard low blocks stores to boot
// - Boot guard high blocks application reads of boot
// - Boot guard high, app vectors: mask boot interrupts
// - Thirteen fuses in high and low groups
// - Serial cannot reach serial-download fuse
// - Debug needs debug and scan fuses programmed
// - Scan fuse enables test port, default 0
// - Serial-download fuse 0 enables serial download
// - Retain fuse keeps EEPROM through chip erase
// - Retain fuse unprogrammable while any lock programmed
// - Boot reset fuse picks boot start vector
// - Brown-out enable and level fuses, default 1
// - Four clock-select fuses, default 0010
// - Chip erase leaves fuses unchanged
`timescale 1ns/1ps
`include "lfp_consts.svh"

module lfp_decode import lfp_pkg::*; #(
  parameter int BOOT_MIN_WORDS = 256,
  parameter int ERASE_CYCLES = `LFP_ERASE_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Device reset that keeps the nonvolatile cells
  input wire logic reloadReq,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // CPU side
  input wire lfp_cpu_req_type cpuReq,
  input wire logic vectorsInBoot,
  output logic storeDeny,
  output logic readDeny,
  output logic irqMask,
  // Programming interface permissions
  output logic memWriteOk,
  output logic memVerifyOk,
  output logic fuseLockSerPar,
  output logic memEraseReq,
  output logic eepromEraseReq,
  // Static configuration
  output lfp_cfg_type cfg
);

  localparam int AW = `LFP_ADDR_W;
  localparam logic [AW:0] FLASH_WORDS = (AW + 1)'(1) << AW;

  lfp_lock_type nvLock_reg;
  lfp_fuse_type nvFuse_reg;
  lfp_lock_type liveLock_reg;
  lfp_fuse_type liveFuse_reg;
  logic sampled_reg;
  lfp_state_type state_reg;
  logic [15:0] eraseCnt_reg;
  logic eraseKeepsEe_reg;
  logic refused_reg;
  logic ackReg;
  logic [31:0] rdData_next;
  logic reqTake;
  logic cmdTake;
  lfp_op_type cmdOp;
  lfp_iface_type cmdIf;
  logic [12:0] cmdData;
  logic busy;
  logic anyLockProg;
  lfp_fuse_type fuseHigh_next;
  logic fuseHighRefused;
  logic [AW-1:0] bootStart;
  logic tgtBoot;

  // Boot section start from boot size: 11 is the smallest section
  function automatic logic [AW-1:0] bootStartOf(input logic [1:0] sz);
    logic [AW:0] words;
    words = (AW + 1)'(BOOT_MIN_WORDS) << (2'd3 - sz);
    return AW'(FLASH_WORDS - words);
  endfunction : bootStartOf

  //--------------------------------------------------------------
  // Wishbone slave
  //--------------------------------------------------------------

  // New request is taken on the edge at which ack rises
  assign reqTake = cyc_i && stb_i && !ackReg;
  assign cmdTake = reqTake && we_i && (sel_i == 4'hf) && (adr_i == `LFP_OFF_CMD);
  assign cmdOp = lfp_op_type'(dat_i[`LFP_CMD_OP_MSB:0]);
  assign cmdIf = lfp_iface_type'(dat_i[`LFP_CMD_IF_MSB:`LFP_CMD_IF_LSB]);
  assign cmdData = dat_i[`LFP_CMD_DAT_MSB:`LFP_CMD_DAT_LSB];
  assign busy = (state_reg != ST_IDLE);

  // Ack answers every access one cycle later, unmapped ones too
  always_ff @(posedge clk) begin
    if (reset) begin
      ackReg <= 1'b0;
    end else if (ce) begin
      ackReg <= reqTake;
    end
  end
  assign ack_o = ackReg;

  // Read mux; unmapped and write-only offsets read as zero
  always_comb begin
    rdData_next = 32'h0;
    if (adr_i == `LFP_OFF_LOCK) begin
      rdData_next[5:0] = liveLock_reg;
    end else if (adr_i == `LFP_OFF_FUSE) begin
      rdData_next[12:0] = liveFuse_reg;
    end else if (adr_i == `LFP_OFF_NV) begin
      rdData_next[5:0] = nvLock_reg;
      rdData_next[`LFP_NV_FUSE_LSB +: 13] = nvFuse_reg;
    end else if (adr_i == `LFP_OFF_STAT) begin
      rdData_next[0] = busy;
      rdData_next[1] = refused_reg;
      rdData_next[2] = sampled_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dat_o <= 32'h0;
    end else if (ce && reqTake) begin
      dat_o <= we_i ? 32'h0 : rdData_next;
    end
  end

  //--------------------------------------------------------------
  // Nonvolatile cells and programming commands
  //--------------------------------------------------------------

  assign anyLockProg = (nvLock_reg != `LFP_LOCK_RST);

  // High fuse group write: serial cannot touch serial-download fuse
  always_comb begin
    fuseHigh_next = nvFuse_reg;
    fuseHighRefused = 1'b0;
    {fuseHigh_next.debugEnableFuse, fuseHigh_next.scanPortEnableFuse,
     fuseHigh_next.serialDownloadEnableFuse, fuseHigh_next.eepromRetainFuse,
     fuseHigh_next.bootSizeSelect, fuseHigh_next.bootResetSelect} = cmdData[6:0];
    if (cmdIf == IF_SERIAL) begin
      fuseHigh_next.serialDownloadEnableFuse = nvFuse_reg.serialDownloadEnableFuse;
    end
    if (!fuseHigh_next.eepromRetainFuse && nvFuse_reg.eepromRetainFuse && anyLockProg) begin
      fuseHigh_next.eepromRetainFuse = 1'b1;
      fuseHighRefused = 1'b1;
    end
  end

  // Lock cells: programming only clears bits, erase only sets them
  always_ff @(posedge clk) begin
    if (reset) begin
      nvLock_reg <= `LFP_LOCK_RST;
    end else if (ce) begin
      if (cmdTake && !busy && cmdOp == OP_LOCK) begin
        nvLock_reg <= nvLock_reg & lfp_lock_type'(cmdData[5:0]);
      end else if (state_reg == ST_ERASE_LOCK) begin
        nvLock_reg <= `LFP_LOCK_RST;
      end
    end
  end

  // Fuse cells; scan port is never fuse-locked, erase never touches them
  always_ff @(posedge clk) begin
    if (reset) begin
      nvFuse_reg <= `LFP_FUSE_RST;
    end else if (ce && cmdTake && !busy) begin
      if (!nvLock_reg.basicLockLow && cmdIf != IF_SCAN) begin
        nvFuse_reg <= nvFuse_reg;
      end else if (cmdOp == OP_FUSE_HIGH) begin
        nvFuse_reg <= fuseHigh_next;
      end else if (cmdOp == OP_FUSE_LOW) begin
        {nvFuse_reg.brownoutLevelFuse, nvFuse_reg.brownoutEnableFuse,
         nvFuse_reg.clockSourceSelect} <= cmdData[5:0];
      end
    end
  end

  // Refused flag tells software whether the last command was dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      refused_reg <= 1'b0;
    end else if (ce && cmdTake) begin
      if (busy) begin
        refused_reg <= 1'b1;
      end else if (cmdOp == OP_FUSE_HIGH || cmdOp == OP_FUSE_LOW) begin
        refused_reg <= (!nvLock_reg.basicLockLow && cmdIf != IF_SCAN)
                       || (cmdOp == OP_FUSE_HIGH && fuseHighRefused);
      end else begin
        refused_reg <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------
  // Chip erase sequence
  //--------------------------------------------------------------

  // Memory goes first; locks only clear once it is fully erased
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      eraseCnt_reg <= 16'h0;
      eraseKeepsEe_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (cmdTake && cmdOp == OP_ERASE) begin
            state_reg <= ST_ERASE_MEM;
            eraseCnt_reg <= 16'(ERASE_CYCLES - 1);
            eraseKeepsEe_reg <= !nvFuse_reg.eepromRetainFuse;
          end
        end
        ST_ERASE_MEM: begin
          if (eraseCnt_reg == 16'h0) begin
            state_reg <= ST_ERASE_LOCK;
          end else begin
            eraseCnt_reg <= eraseCnt_reg - 16'h1;
          end
        end
        ST_ERASE_LOCK: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Erase strobes to the memory arrays
  always_ff @(posedge clk) begin
    if (reset) begin
      memEraseReq <= 1'b0;
      eepromEraseReq <= 1'b0;
    end else if (ce) begin
      memEraseReq <= (state_reg == ST_ERASE_MEM);
      eepromEraseReq <= (state_reg == ST_ERASE_MEM) && !eraseKeepsEe_reg;
    end
  end

  // Programming permissions follow the cells one cycle later, not the copy
  always_ff @(posedge clk) begin
    if (reset) begin
      memWriteOk <= 1'b1;
      memVerifyOk <= 1'b1;
      fuseLockSerPar <= 1'b0;
    end else if (ce) begin
      memWriteOk <= nvLock_reg.basicLockLow;
      memVerifyOk <= nvLock_reg.basicLockHigh;
      fuseLockSerPar <= !nvLock_reg.basicLockLow;
    end
  end

  //--------------------------------------------------------------
  // Reset sampling of live copies
  //--------------------------------------------------------------

  // Live copy loads after reset release and on each device reset, so
  // new fuse or guard values only reach cfg and the CPU verdicts after the next reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sampled_reg <= 1'b0;
      liveLock_reg <= `LFP_LOCK_RST;
      liveFuse_reg <= `LFP_FUSE_RST;
    end else if (ce && (!sampled_reg || reloadReq)) begin
      sampled_reg <= 1'b1;
      liveLock_reg <= nvLock_reg;
      liveFuse_reg <= nvFuse_reg;
    end
  end

  //--------------------------------------------------------------
  // Static configuration decode
  //--------------------------------------------------------------

  assign bootStart = bootStartOf(liveFuse_reg.bootSizeSelect);

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= '0;
    end else if (ce) begin
      cfg.debugOn <= !liveFuse_reg.debugEnableFuse && !liveFuse_reg.scanPortEnableFuse;
      cfg.scanPortOn <= !liveFuse_reg.scanPortEnableFuse;
      cfg.serialDownloadOn <= !liveFuse_reg.serialDownloadEnableFuse;
      cfg.brownoutOn <= !liveFuse_reg.brownoutEnableFuse;
      cfg.brownoutLevel <= liveFuse_reg.brownoutLevelFuse;
      cfg.clockSource <= liveFuse_reg.clockSourceSelect;
      cfg.resetVector <= liveFuse_reg.bootResetSelect ? '0 : bootStart;
    end
  end

  //--------------------------------------------------------------
  // CPU store and read guards
  //--------------------------------------------------------------

  assign tgtBoot = (cpuReq.addr >= bootStart);

  // Verdicts lag the request by one cycle; the fetch stage must wait
  always_ff @(posedge clk) begin
    if (reset) begin
      storeDeny <= 1'b0;
      readDeny <= 1'b0;
      irqMask <= 1'b0;
    end else if (ce) begin
      storeDeny <= cpuReq.store && (tgtBoot ? !liveLock_reg.bootGuardLow
                                            : !liveLock_reg.appGuardLow);
      readDeny <= cpuReq.read
        && ((cpuReq.inBoot && !tgtBoot && !liveLock_reg.appGuardHigh)
        || (!cpuReq.inBoot && tgtBoot && !liveLock_reg.bootGuardHigh));
      irqMask <= (vectorsInBoot && !cpuReq.inBoot && !liveLock_reg.appGuardHigh)
        || (!vectorsInBoot && cpuReq.inBoot && !liveLock_reg.bootGuardHigh);
    end
  end

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------

  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  lock_only_clears_a: assert property (ce && state_reg != ST_ERASE_LOCK |=>
      ((nvLock_reg & ~$past(nvLock_reg)) == 6'h0))
    else $error("lock bit returned to one outside erase");
  erase_sets_locks_a: assert property ($rose(state_reg == ST_ERASE_LOCK) && ce |=>
      nvLock_reg == `LFP_LOCK_RST)
    else $error("chip erase did not clear locks");
  erase_keeps_fuse_a: assert property (busy |=> $stable(nvFuse_reg))
    else $error("fuses changed during chip erase");
  fuse_lock_a: assert property (ce && cmdTake && !busy && !nvLock_reg.basicLockLow
      && cmdIf != IF_SCAN |=> $stable(nvFuse_reg))
    else $error("locked fuse write took effect");
  serial_fuse_a: assert property (ce && cmdTake && cmdIf == IF_SERIAL |=>
      $stable(nvFuse_reg.serialDownloadEnableFuse))
    else $error("serial write reached serial-download fuse");
  retain_lock_a: assert property (anyLockProg && nvFuse_reg.eepromRetainFuse |=>
      nvFuse_reg.eepromRetainFuse)
    else $error("retain fuse programmed under lock");
  debug_gate_a: assert property (ce && liveFuse_reg.scanPortEnableFuse |=>
      !cfg.debugOn)
    else $error("debug on without scan port fuse");
  app_store_a: assert property (ce && cpuReq.store && !tgtBoot
      && !liveLock_reg.appGuardLow |=> storeDeny)
    else $error("store into guarded application passed");
  boot_read_a: assert property (ce && cpuReq.read && !cpuReq.inBoot && tgtBoot
      && !liveLock_reg.bootGuardHigh |=> readDeny)
    else $error("application read of guarded boot passed");
  erase_length_a: assert property ($rose(memEraseReq) |-> ##[1:300]
      !memEraseReq)
    else $error("memory erase did not end");
  verify_lock_a: assert property (ce && !nvLock_reg.basicLockHigh |=> !memVerifyOk)
    else $error("verify allowed in lock mode three");

  erase_run_c: cover property (state_reg == ST_ERASE_MEM ##[1:300] state_reg == ST_IDLE);
  refuse_c: cover property (cmdTake && !nvLock_reg.basicLockLow ##1 refused_reg);
  irq_mask_c: cover property (irqMask && vectorsInBoot);

endmodule : lfp_decode

// *** bench/lfp_cpu_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Boot loader and application code model
// ----------------------------------------
module lfp_cpu_model import lfp_pkg::*; (
  // Clock
  clk,
  // Requests toward the guard logic
  cpuReq,
  vectorsInBoot,
  // Verdicts coming back
  storeDeny,
  readDeny,
  irqMask
);
  input wire logic clk;
  output lfp_cpu_req_type cpuReq;
  output logic vectorsInBoot;
  input wire logic storeDeny;
  input wire logic readDeny;
  input wire logic irqMask;

  // Idle until the bench asks for an access
  initial begin
    cpuReq = '0;
    vectorsInBoot = 1'b0;
  end

  // One request for one cycle; the idle address is inverted so no stale value lingers
  task automatic access(input logic ib, input logic st, input logic rd,
                        input logic [13:0] a, input logic vib, output logic [2:0] res);
    @(posedge clk);
    cpuReq <= '{inBoot: ib, store: st, read: rd, addr: a};
    vectorsInBoot <= vib;
    @(posedge clk);
    cpuReq <= '{inBoot: ib, store: 1'b0, read: 1'b0, addr: ~a};
    @(posedge clk);
    res = {storeDeny, readDeny, irqMask};
  endtask : access
endmodule : lfp_cpu_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import lfp_pkg::*;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, reloadReq = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, storeDeny, readDeny, irqMask;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] datI = 32'h0, datO, rd;
  logic memWriteOk, memVerifyOk, fuseLockSerPar, memEraseReq, eepromEraseReq;
  logic [2:0] res;
  lfp_cpu_req_type cpuReq;
  logic vectorsInBoot;
  lfp_cfg_type cfg;
  int err_count = 0, comparisons = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  lfp_decode #(.BOOT_MIN_WORDS(256), .ERASE_CYCLES(16)) i_dut (.clk(clk), .reset(reset),
    .ce(ce), .reloadReq(reloadReq), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack), .cpuReq(cpuReq),
    .vectorsInBoot(vectorsInBoot), .storeDeny(storeDeny), .readDeny(readDeny),
    .irqMask(irqMask), .memWriteOk(memWriteOk), .memVerifyOk(memVerifyOk),
    .fuseLockSerPar(fuseLockSerPar), .memEraseReq(memEraseReq),
    .eepromEraseReq(eepromEraseReq), .cfg(cfg));

  lfp_cpu_model i_cpu (.clk(clk), .cpuReq(cpuReq), .vectorsInBoot(vectorsInBoot),
    .storeDeny(storeDeny), .readDeny(readDeny), .irqMask(irqMask));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = datO;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Reload the live copy without touching the cells, then let cfg settle
  task automatic reload();
    @(posedge clk);
    reloadReq <= 1'b1;
    @(posedge clk);
    reloadReq <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : reload

  task automatic perm(input logic [2:0] exp);
    repeat (3) @(posedge clk);
    chk("perm", 32'(exp), 32'({memWriteOk, memVerifyOk, fuseLockSerPar}));
  endtask : perm

  task automatic cpu(input logic ib, st, r, input logic [13:0] a, input logic vib,
                     input logic [2:0] exp);
    i_cpu.access(ib, st, r, a, vib, res);
    chk("cpu verdict", 32'(exp), 32'(res));
  endtask : cpu

  // Counts erase strobes; busy must be clear afterwards
  task automatic eraseRun(input logic expEe);
    int mc, ec;
    mc = 0;
    ec = 0;
    wb(8'h0c, 1'b1, 32'h4);
    repeat (40) begin
      @(posedge clk);
      if (memEraseReq === 1'b1) mc++;
      if (eepromEraseReq === 1'b1) ec++;
    end
    chk("mem erase len", 32'd16, 32'(mc));
    chk("eeprom erase len", expEe ? 32'd16 : 32'd0, 32'(ec));
    wb(8'h10, 1'b0, 32'h0);
    chk("busy", 32'h0, {31'h0, rd[0]});
  endtask : eraseRun

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testDefaults();
    wb(8'h00, 1'b0, 32'h0);
    chk("lock", 32'h3f, rd);
    wb(8'h04, 1'b0, 32'h0);
    chk("fuse", 32'h13f2, rd);
    chk("cfg", 32'(23'h348000), 32'(cfg));
    perm(3'b110);
    wb(8'h40, 1'b1, 32'hffff_ffff);
    wb(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    cpu(1'b0, 1'b1, 1'b0, 14'h0100, 1'b0, 3'b000);
    cpu(1'b0, 1'b1, 1'b0, 14'h3f10, 1'b0, 3'b000);
    cpu(1'b1, 1'b0, 1'b1, 14'h0100, 1'b0, 3'b000);
  endtask : testDefaults

  // Fuses are programmed before any lock bit
  task automatic testFuses();
    wb(8'h0c, 1'b1, 32'h000e0002);
    wb(8'h0c, 1'b1, 32'h00220003);
    wb(8'h0c, 1'b1, 32'h001e0012);
    wb(8'h08, 1'b0, 32'h0);
    chk("nv fuses", 32'h03a2003f, rd);
    reload();
    chk("cfg", 32'(23'h7cbf00), 32'(cfg));
  endtask : testFuses

  task automatic testLocks();
    wb(8'h0c, 1'b1, 32'h003e0001);
    perm(3'b011);
    wb(8'h0c, 1'b1, 32'h003f0003);
    wb(8'h10, 1'b0, 32'h0);
    chk("refused", 32'h1, {31'h0, rd[1]});
    wb(8'h0c, 1'b1, 32'h00060022);
    wb(8'h08, 1'b0, 32'h0);
    chk("nv locked", 32'h03a2003e, rd);
    wb(8'h0c, 1'b1, 32'h003c0001);
    perm(3'b001);
    wb(8'h0c, 1'b1, 32'h003f0001);
    wb(8'h08, 1'b0, 32'h0);
    chk("nv no clear", 32'h03a2003c, rd);
  endtask : testLocks

  task automatic testGuards();
    wb(8'h0c, 1'b1, 32'h00000001);
    reload();
    cpu(1'b0, 1'b1, 1'b0, 14'h0100, 1'b0, 3'b100);
    cpu(1'b0, 1'b1, 1'b0, 14'h3f10, 1'b0, 3'b100);
    cpu(1'b1, 1'b0, 1'b1, 14'h0100, 1'b0, 3'b011);
    cpu(1'b0, 1'b0, 1'b1, 14'h3f10, 1'b1, 3'b011);
    cpu(1'b1, 1'b0, 1'b1, 14'h3f10, 1'b1, 3'b000);
  endtask : testGuards

  task automatic testErase();
    eraseRun(1'b1);
    wb(8'h08, 1'b0, 32'h0);
    chk("nv after erase", 32'h03a2003f, rd);
    wb(8'h0c, 1'b1, 32'h00060002);
    eraseRun(1'b0);
    wb(8'h08, 1'b0, 32'h0);
    chk("nv retain", 32'h01a2003f, rd);
    // Scan fuse off hides the debug fuse; largest boot size moves the vector
    wb(8'h0c, 1'b1, 32'h00200002);
    wb(8'h08, 1'b0, 32'h0);
    chk("nv scan off", 32'h0822003f, rd);
    reload();
    chk("cfg scan off", 32'(23'h1cb800), 32'(cfg));
  endtask : testErase

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // Main sequence after a 16 cycle reset
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    testDefaults();
    testFuses();
    testLocks();
    testGuards();
    testErase();
    results();
  end

  // Watchdog well beyond the expected run of about 230 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : testbench
